// File: hdl/bps_pkg.sv
// Constants, types and field layouts for the bridge PWM output steering block
// Contract
// - Two-bit mode field selects single, half-bridge, full forward or full reverse.
// - Duty is ten bits: high byte register on top, two low bits from control.
// - On period match the timer clears, output sets unless duty zero, duty latches.
// - Dead-band counts instruction cycles of four oscillator periods each.
// - Half-bridge drives PWM on pin a and its complement on pin b.
// - Half-bridge delays each output's activation by the seven-bit dead-band count.
// - Dead-band longer than an output's active time keeps it inactive all cycle.
// - Full-bridge uses all four pins; firmware makes all four outputs.
// - Forward: pin a active, pin d modulated, pins b and c inactive.
// - Reverse: pin c active, pin b modulated, pins a and d inactive.
// - A direction toggle in full-bridge takes effect from the next PWM cycle.
// - Three timer cycles before period end, blank modulated pins and swap statics.
// - After a swap, modulation resumes on the new pin at next period start.
// - Full-bridge applies no dead-band delay.
// - Two polarity bits set active level for pair a/c and pair b/d.
// - Period match flag sets as the second period begins, marking a full cycle.
package bps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUTY = 8'h01;
  localparam logic [7:0] ADDR_PERIOD = 8'h02;
  localparam logic [7:0] ADDR_TIMER = 8'h03;
  localparam logic [7:0] ADDR_AUX = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h05;
  localparam logic [7:0] ADDR_DIR = 8'h06;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic [6:0] AUX_RST = 7'h00;
  localparam logic [3:0] DIR_RST = 4'hF;
  localparam int FLAG_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int TOSC_NS = 25;
  localparam int CLK_NS = 25;
  localparam int OSC_PER_INSTR = 4;
  localparam int CLK_PER_INSTR = (OSC_PER_INSTR * TOSC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] PHASE_LAST = 2'(CLK_PER_INSTR - 1);
  localparam logic [8:0] SWAP_LEAD = 9'h004;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0]
  {
    MODE_SINGLE = 2'b00,
    MODE_FWD = 2'b01,
    MODE_HALF = 2'b10,
    MODE_REV = 2'b11
  } bps_mode_t;

  typedef enum logic [2:0]
  {
    ST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_SWAP = 3'b100
  } bps_state_t;

  typedef struct packed
  {
    bps_mode_t mode;
    logic [1:0] duty_low_bits;
    logic enable;
    logic spare;
    logic [1:0] pair_polarity_select;
  } bps_ctrl_t;

  typedef struct packed
  {
    logic d;
    logic c;
    logic b;
    logic a;
  } bps_pins_t;

endpackage : bps_pkg

// File: hdl/bps_timebase.sv
// Period timer, duty double buffer and raw PWM waveform
`timescale 1ns/1ps
`default_nettype none
module bps_timebase
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [7:0] period_value,
  input wire logic [9:0] duty,
  output logic instr_tick,
  output logic new_period,
  output logic swap_point,
  output logic [7:0] timer_q,
  output logic pwm_q
);

  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [7:0] timer_d;
  logic [9:0] duty_lat_q;
  logic [9:0] duty_lat_d;
  logic pwm_d;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle is four clocks; phase forms the low two time-base bits
  always_comb
  begin
    instr_tick = run && (phase_q == PHASE_LAST);
    new_period = instr_tick && (timer_q == period_value);
    swap_point = instr_tick && ((9'({1'b0, timer_q}) + SWAP_LEAD) == (9'({1'b0, period_value}) + 9'h001));
    phase_d = run ? 2'(phase_q + 2'h1) : 2'h0;
    timer_d = timer_q;
    duty_lat_d = duty_lat_q;
    pwm_d = pwm_q;
    if (!run)
    begin
      timer_d = 8'h00;
      pwm_d = 1'b0;
    end
    else if (new_period)
    begin
      timer_d = 8'h00;
      duty_lat_d = duty;
      pwm_d = (duty != 10'h000);
    end
    else
    begin
      if (instr_tick)
      begin
        timer_d = 8'(timer_q + 8'h01);
      end
      // Drop one clock early so the pulse spans exactly duty clocks
      if ({timer_q, phase_q} == 10'(duty_lat_q - 10'h001))
      begin
        pwm_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phase_q <= 2'h0;
      timer_q <= 8'h00;
      duty_lat_q <= 10'h000;
      pwm_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      timer_q <= timer_d;
      duty_lat_q <= duty_lat_d;
      pwm_q <= pwm_d;
    end
  end

endmodule : bps_timebase
`default_nettype wire

// File: hdl/bps_deadband.sv
// Rising-edge delay in instruction cycles for one half-bridge output
`timescale 1ns/1ps
`default_nettype none
module bps_deadband
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_tick,
  input wire logic level,
  input wire logic [6:0] deadband_count,
  output logic out_q
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic out_d;

  always_comb
  begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!level)
    begin
      cnt_d = 7'h00;
      out_d = 1'b0;
    end
    else if (!out_q)
    begin
      if (cnt_q == deadband_count)
      begin
        out_d = 1'b1;
      end
      else if (instr_tick)
      begin
        cnt_d = 7'(cnt_q + 7'h01);
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_q <= 7'h00;
      out_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

endmodule : bps_deadband
`default_nettype wire

// File: hdl/bps_steering.sv
// Enhanced PWM output steering: registers, bridge sequencing, pin drive
`timescale 1ns/1ps
`default_nettype none
module bps_steering
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output bps_pins_t pin_out,
  output bps_pins_t pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  bps_ctrl_t ctrl_q;
  bps_ctrl_t ctrl_d;
  logic [7:0] duty_high_byte_q;
  logic [7:0] duty_high_byte_d;
  logic [7:0] period_value_q;
  logic [7:0] period_value_d;
  logic [6:0] deadband_count_q;
  logic [6:0] deadband_count_d;
  logic period_match_flag_q;
  logic period_match_flag_d;
  logic [3:0] pin_direction_q;
  logic [3:0] pin_direction_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Bridge sequencing and pins
  bps_state_t state_q;
  bps_state_t state_d;
  logic reverse_q;
  logic reverse_d;
  bps_pins_t pins_q;
  bps_pins_t pins_d;

  logic instr_tick;
  logic new_period;
  logic swap_point;
  logic [7:0] timer_val;
  logic pwm_raw;
  logic db_a;
  logic db_b;
  logic active;
  logic full_mode;
  logic want_reverse;

  function automatic logic is_full(input bps_mode_t m);
    is_full = (m == MODE_FWD) || (m == MODE_REV);
  endfunction : is_full

  assign full_mode = is_full(ctrl_q.mode);
  assign want_reverse = ctrl_q.mode[1];
  assign active = (state_q != ST_WAIT);

  ////////////////////////////////////////////////////////////////////////////
  // Time base and dead-band stages
  bps_timebase u_timebase
  (
    .clk(clk),
    .reset(reset),
    .run(ctrl_q.enable),
    .period_value(period_value_q),
    .duty({duty_high_byte_q, ctrl_q.duty_low_bits}),
    .instr_tick(instr_tick),
    .new_period(new_period),
    .swap_point(swap_point),
    .timer_q(timer_val),
    .pwm_q(pwm_raw)
  );

  bps_deadband u_db_a
  (
    .clk(clk),
    .reset(reset),
    .instr_tick(instr_tick),
    .level(active && pwm_raw),
    .deadband_count(deadband_count_q),
    .out_q(db_a)
  );

  bps_deadband u_db_b
  (
    .clk(clk),
    .reset(reset),
    .instr_tick(instr_tick),
    .level(active && !pwm_raw),
    .deadband_count(deadband_count_q),
    .out_q(db_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, flag and read data
  always_comb
  begin
    ctrl_d = ctrl_q;
    duty_high_byte_d = duty_high_byte_q;
    period_value_d = period_value_q;
    deadband_count_d = deadband_count_q;
    period_match_flag_d = period_match_flag_q;
    pin_direction_d = pin_direction_q;
    rdata_d = 8'h00;
    if (reg_wr)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        ctrl_d = bps_ctrl_t'(reg_wdata);
      end
      else if (reg_addr == ADDR_DUTY)
      begin
        duty_high_byte_d = reg_wdata;
      end
      else if (reg_addr == ADDR_PERIOD)
      begin
        period_value_d = reg_wdata;
      end
      else if (reg_addr == ADDR_AUX)
      begin
        deadband_count_d = reg_wdata[6:0];
      end
      else if (reg_addr == ADDR_FLAG)
      begin
        if (reg_wdata[FLAG_BIT])
        begin
          period_match_flag_d = 1'b0;
        end
      end
      else if (reg_addr == ADDR_DIR)
      begin
        pin_direction_d = reg_wdata[3:0];
      end
    end
    if (new_period)
    begin
      period_match_flag_d = 1'b1;
    end
    if (reg_rd)
    begin
      if (reg_addr == ADDR_CTRL)
      begin
        rdata_d = 8'(ctrl_q);
      end
      else if (reg_addr == ADDR_DUTY)
      begin
        rdata_d = duty_high_byte_q;
      end
      else if (reg_addr == ADDR_PERIOD)
      begin
        rdata_d = period_value_q;
      end
      else if (reg_addr == ADDR_TIMER)
      begin
        rdata_d = timer_val;
      end
      else if (reg_addr == ADDR_AUX)
      begin
        rdata_d = {1'b0, deadband_count_q};
      end
      else if (reg_addr == ADDR_FLAG)
      begin
        rdata_d = {7'h00, period_match_flag_q};
      end
      else if (reg_addr == ADDR_DIR)
      begin
        rdata_d = {4'h0, pin_direction_q};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_q <= bps_ctrl_t'(CTRL_RST);
      duty_high_byte_q <= DUTY_RST;
      period_value_q <= PERIOD_RST;
      deadband_count_q <= AUX_RST;
      period_match_flag_q <= 1'b0;
      pin_direction_q <= DIR_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      duty_high_byte_q <= duty_high_byte_d;
      period_value_q <= period_value_d;
      deadband_count_q <= deadband_count_d;
      period_match_flag_q <= period_match_flag_d;
      pin_direction_q <= pin_direction_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Start on a period boundary, direction change sequencing
  always_comb
  begin
    state_d = state_q;
    reverse_d = reverse_q;
    case (state_q)
      ST_WAIT:
      begin
        reverse_d = want_reverse;
        if (new_period)
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!ctrl_q.enable)
        begin
          state_d = ST_WAIT;
        end
        else if (!full_mode)
        begin
          reverse_d = want_reverse;
        end
        else if (want_reverse != reverse_q)
        begin
          if (swap_point)
          begin
            state_d = ST_SWAP;
            reverse_d = want_reverse;
          end
          else if (new_period)
          begin
            reverse_d = want_reverse;
          end
        end
      end
      ST_SWAP:
      begin
        if (!ctrl_q.enable)
        begin
          state_d = ST_WAIT;
        end
        else if (new_period)
        begin
          state_d = ST_RUN;
        end
      end
      default:
      begin
        state_d = ST_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin steering per mode, polarity per pair
  always_comb
  begin
    pins_d = '0;
    if (active)
    begin
      case (ctrl_q.mode)
        MODE_SINGLE:
        begin
          pins_d.a = pwm_raw;
        end
        MODE_HALF:
        begin
          pins_d.a = db_a;
          pins_d.b = db_b;
        end
        default:
        begin
          // Full bridge: raw waveform, modulation blanked during swap
          pins_d.a = !reverse_q;
          pins_d.d = !reverse_q && pwm_raw && (state_q != ST_SWAP);
          pins_d.c = reverse_q;
          pins_d.b = reverse_q && pwm_raw && (state_q != ST_SWAP);
        end
      endcase
    end
    pins_d.a = pins_d.a ^ ctrl_q.pair_polarity_select[0];
    pins_d.c = pins_d.c ^ ctrl_q.pair_polarity_select[0];
    pins_d.b = pins_d.b ^ ctrl_q.pair_polarity_select[1];
    pins_d.d = pins_d.d ^ ctrl_q.pair_polarity_select[1];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_WAIT;
      reverse_q <= 1'b0;
      pins_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      reverse_q <= reverse_d;
      pins_q <= pins_d;
    end
  end

  assign pin_out = pins_q;
  assign pin_oe = bps_pins_t'(~pin_direction_q);

endmodule : bps_steering
`default_nettype wire

// File: bench/bps_steering_asserts.sv
// Checker for pin steering and register port of the steering block
`timescale 1ns/1ps
`default_nettype none
module bps_steering_asserts
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire bps_pins_t pin_out,
  input wire bps_pins_t pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  bps_ctrl_t ctrl_q;
  logic [7:0] per_q;
  logic [1:0] age_q;
  logic [3:0] act;
  logic wr_ctrl;
  logic quiet;
  assign wr_ctrl = reg_wr && reg_addr == ADDR_CTRL;
  assign quiet = age_q == 2'h3;
  assign act = pin_out ^ {ctrl_q.pair_polarity_select, ctrl_q.pair_polarity_select};
  // Shadow of control and period, age since last control write
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrl_q <= CTRL_RST;
      per_q <= PERIOD_RST;
      age_q <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_PERIOD)
        per_q <= reg_wdata;
      if (wr_ctrl)
        age_q <= 2'h0;
      else if (!quiet)
        age_q <= age_q + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_rev_req;
    wr_ctrl && reg_wdata[7:6] == MODE_REV && ctrl_q.mode == MODE_FWD && act[0];
  endsequence
  sequence s_hold;
    (act[0] && !act[2]) [*8];
  endsequence
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_oe;
    reg_wr && reg_addr == ADDR_DIR |=> pin_oe == ~$past(reg_wdata[3:0]);
  endproperty
  property p_ac;
    quiet |-> !(act[0] && act[2]);
  endproperty
  property p_bd;
    quiet |-> !(act[1] && act[3]);
  endproperty
  property p_half;
    quiet && ctrl_q.mode == MODE_HALF |-> !(act[0] && act[1]) && act[3:2] == 2'h0;
  endproperty
  property p_single;
    quiet && ctrl_q.mode == MODE_SINGLE |-> act[3:1] == 3'h0;
  endproperty
  property p_off;
    quiet && !ctrl_q.enable |-> act == 4'h0;
  endproperty
  property p_dir_hold;
    s_rev_req |=> s_hold;
  endproperty
  property p_timer;
    reg_rd && reg_addr == ADDR_TIMER |=> reg_rdata <= per_q;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_oe: assert property (p_oe)
    else $error("output enable differs from direction");
  a_ac: assert property (p_ac)
    else $error("pins a and c active together");
  a_bd: assert property (p_bd)
    else $error("pins b and d active together");
  a_half: assert property (p_half)
    else $error("half bridge overlap");
  a_single: assert property (p_single)
    else $error("single mode drives b, c or d");
  a_off: assert property (p_off)
    else $error("disabled pins not at inactive level");
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed at once");
  a_timer: assert property (p_timer)
    else $error("timer above period");
endmodule : bps_steering_asserts
bind bps_steering bps_steering_asserts u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// File: bench/bps_bridge_model.sv
// Power-switch driver model with pull-downs on released pins
`timescale 1ns/1ps
`default_nettype none
module bps_bridge_model
  import bps_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire bps_pins_t pin_out,
  input wire bps_pins_t pin_oe,
  output logic [3:0] level,
  output int shoot
);
  assign level = pin_out & pin_oe;
  // Counts cycles with both switches of one leg on
  always @(posedge clk)
    if (reset)
      shoot <= 0;
    else if ((level[0] && level[1]) || (level[2] && level[3]))
      shoot <= shoot + 1;
endmodule : bps_bridge_model
`default_nettype wire

// File: bench/bps_steering_tb.sv
// Self-checking bench for the steering block
`timescale 1ns/1ps
`default_nettype none
module bps_steering_tb;
  import bps_pkg::*;
  localparam int L = 80;
  logic clk, reset, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  bps_pins_t pin_out, pin_oe;
  logic [3:0] level, act;
  logic [1:0] pol;
  int shoot, miscompares, n_checks, cyc, d, n, seed;
  int c[4], lo[4], hi[4];
  bps_steering dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe));
  bps_bridge_model far (.clk(clk), .reset(reset), .pin_out(pin_out), .pin_oe(pin_oe),
    .level(level), .shoot(shoot));
  assign act = pin_out ^ {pol, pol};
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic fail(input int g, e);
    miscompares++;
    $display("[FAIL] %0t got %0d exp %0d", $time, g, e);
  endtask : fail
  task automatic chk(input int g, l, h);
    n_checks++;
    if (g < l || g > h)
      fail(g, l);
  endtask : chk
  task automatic chk8(input logic [7:0] g, e);
    n_checks++;
    if (g !== e)
      fail(g, e);
  endtask : chk8
  task automatic wr(input logic [7:0] a, w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, e);
    rd(a, v);
    chk8(v, e);
  endtask : rdc
  task automatic wait_flag;
    int k;
    k = 0;
    v = 8'h00;
    while (v[FLAG_BIT] !== 1'b1 && k < 300)
    begin
      rd(ADDR_FLAG, v);
      k++;
    end
    chk(k, 36, 44);
    wr(ADDR_FLAG, 8'h01);
  endtask : wait_flag
  task automatic wait_act(input int b, input logic x);
    int k;
    k = 0;
    while (act[b] !== x && k < 400)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk(k, 0, 399);
  endtask : wait_act
  task automatic setup(input logic [1:0] m, input int dd, input logic [6:0] nb);
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_PERIOD, 8'(L / 4 - 1));
    wr(ADDR_DUTY, 8'(dd >> 2));
    wr(ADDR_AUX, {1'b0, nb});
    wr(ADDR_FLAG, 8'h01);
    wr(ADDR_CTRL, {m, 2'(dd), 2'b10, pol});
    wait_flag();
  endtask : setup
  task automatic meas(input logic [1:0] m);
    c = '{0, 0, 0, 0};
    repeat (L)
    begin
      @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++)
        c[i] += act[i];
    end
    lo = '{0, 0, 0, 0};
    case (m)
      MODE_SINGLE: lo[0] = d;
      MODE_FWD: lo = '{L, 0, 0, d};
      MODE_REV: lo = '{0, d, L, 0};
      default: lo = '{d - 4 * n, L - d - 4 * n, 0, 0};
    endcase
    hi = lo;
    for (int i = 0; i < 2; i++)
      if (m == MODE_HALF)
        hi[i] = (lo[i] + 3 < 0) ? 0 : lo[i] + 3;
    for (int i = 0; i < 4; i++)
      chk(c[i], lo[i], hi[i]);
  endtask : meas
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hca6c9d76;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pol = 2'b00;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdc(ADDR_CTRL, CTRL_RST);
    rdc(ADDR_PERIOD, PERIOD_RST);
    rdc(ADDR_DIR, {4'h0, DIR_RST});
    chk8({4'h0, pin_oe}, 8'h00);
    wr(ADDR_AUX, 8'hFF);
    rdc(ADDR_AUX, 8'h7F);
    wr(ADDR_TIMER, 8'h55);
    rdc(ADDR_TIMER, 8'h00);
    wr(8'h07, 8'h33);
    rdc(8'h07, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 8; k++)
    begin
      pol = 2'({$random(seed)});
      d = (k == 0) ? 0 : 1 + {$random(seed)} % (L - 1);
      n = (k == 6) ? 127 : 1 + {$random(seed)} % 4;
      setup(2'(k), d, 7'(n));
      meas(2'(k));
    end
    $display("test modes done");
    pol = 2'b00;
    d = 30;
    setup(MODE_FWD, d, 7'h00);
    wr(ADDR_DIR, 8'h00);
    #1 chk8({4'h0, pin_oe}, 8'h0F);
    wait_act(3, 1'b0);
    wait_act(3, 1'b1);
    wr(ADDR_CTRL, {MODE_REV, 2'(d), 2'b10, pol});
    repeat (L - 26) @(posedge clk);
    #1 chk8({4'h0, level}, 8'h01);
    repeat (20) @(posedge clk);
    #1 chk8({4'h0, level}, 8'h04);
    repeat (8) @(posedge clk);
    #1 chk8({4'h0, level}, 8'h06);
    chk(shoot, 0, 0);
    $display("test direction done");
    end_of_test();
  end
endmodule : bps_steering_tb
`default_nettype wire
